// [hdl/pmbus_guard_pkg.sv]
/*
 * Shared constants for the PMBus write guard, configuration save/reload,
 * bus feature report and alert suppression logic.
 * Assumes a PMBus link layer outside that frames transactions into
 * decoded commands and that the user store is a byte-wide NVM port.
 */
package pmbus_guard_pkg;

    // Command codes served or checked by this block.
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
    localparam logic [7:0] CMD_WRITE_GUARD = 8'h10;
    localparam logic [7:0] CMD_SAVE_CONFIG = 8'h15;
    localparam logic [7:0] CMD_RELOAD_CONFIG = 8'h16;
    localparam logic [7:0] CMD_FEATURE_REPORT = 8'h19;
    localparam logic [7:0] CMD_ALERT_SUPPRESS = 8'h1B;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_SETPOINT = 8'h21;

    // Write guard levels.
    localparam logic [7:0] GUARD_OPEN = 8'h00;
    localparam logic [7:0] GUARD_KEEP_SETPOINT = 8'h20;
    localparam logic [7:0] GUARD_KEEP_OPERATION = 8'h40;
    localparam logic [7:0] GUARD_KEEP_SAVE = 8'h80;
    localparam logic [7:0] WRITE_GUARD_RESET = 8'h00;

    // Phase selection meaning all phases.
    localparam logic [7:0] PHASE_ALL = 8'hFF;

    // Status code that selects the output-voltage mask.
    localparam logic [7:0] STATUS_VOUT_CODE = 8'h7A;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // Bus feature report layout.
    localparam int FEAT_PACKET_CHECK_BIT = 7;
    localparam int FEAT_SPEED_LSB = 5;
    localparam logic [1:0] FEAT_SPEED_1MHZ = 2'h2;
    localparam int FEAT_ALERT_BIT = 4;
    localparam int FEAT_FORMAT_BIT = 3;
    localparam int FEAT_ADAPTIVE_VOLTAGE_BUS_BIT = 2;

    // First user-store address used for the block's own items.
    localparam logic [7:0] ITEM_NVM_BASE = 8'h00;

    // Least wait the host keeps after a save before the next command.
    localparam int HOST_SETTLE_MS = 100;

    // Transaction kinds as framed by the link layer.
    typedef enum logic [2:0] {
        KIND_SEND_BYTE = 3'b000,
        KIND_WRITE_BYTE = 3'b001,
        KIND_WRITE_WORD = 3'b010,
        KIND_READ_BYTE = 3'b011,
        KIND_PROCESS_CALL = 3'b100
    } cmd_kind_e;

    // Save and reload sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SAVE_STEP = 3'b001,
        ST_SAVE_WAIT = 3'b010,
        ST_LOAD_STEP = 3'b011,
        ST_LOAD_WAIT = 3'b100,
        ST_OVERRIDE = 3'b101
    } nvm_state_e;

endpackage : pmbus_guard_pkg

// [hdl/pmbus_write_gate.sv]
/*
 * Write guard decision: whether a write to a command code is allowed at
 * the current guard level, and whether a proposed guard level is valid.
 * Purely combinational; the caller registers the outcome.
 */
`timescale 1ns/10ps
`default_nettype none
module pmbus_write_gate (
    input wire logic [7:0] guard_level,
    input wire logic [7:0] code,
    input wire logic [7:0] proposed_level,
    output logic write_allowed,
    output logic proposed_valid
);

    // The guard itself and the save command stay writable at every level.
    always_comb begin
        write_allowed = 1'b0;
        if (code == pmbus_guard_pkg::CMD_WRITE_GUARD || code == pmbus_guard_pkg::CMD_SAVE_CONFIG) begin
            write_allowed = 1'b1;
        end else begin
            case (guard_level)
                pmbus_guard_pkg::GUARD_OPEN: begin
                    write_allowed = 1'b1;
                end
                pmbus_guard_pkg::GUARD_KEEP_SETPOINT: begin
                    write_allowed = (code == pmbus_guard_pkg::CMD_OPERATION) ||
                                    (code == pmbus_guard_pkg::CMD_ON_OFF_CONFIG) ||
                                    (code == pmbus_guard_pkg::CMD_OUTPUT_VOLTAGE_SETPOINT);
                end
                pmbus_guard_pkg::GUARD_KEEP_OPERATION: begin
                    write_allowed = (code == pmbus_guard_pkg::CMD_OPERATION);
                end
                pmbus_guard_pkg::GUARD_KEEP_SAVE: begin
                    write_allowed = 1'b0;
                end
                default: begin
                    write_allowed = 1'b0;
                end
            endcase
        end
    end

    // Only the four defined codes are accepted as a new level.
    assign proposed_valid = (proposed_level == pmbus_guard_pkg::GUARD_OPEN) ||
                            (proposed_level == pmbus_guard_pkg::GUARD_KEEP_SETPOINT) ||
                            (proposed_level == pmbus_guard_pkg::GUARD_KEEP_OPERATION) ||
                            (proposed_level == pmbus_guard_pkg::GUARD_KEEP_SAVE);

endmodule : pmbus_write_gate
`default_nettype wire

// [hdl/alert_suppress_gate.sv]
/*
 * Alert gating: each status byte is masked by its suppress byte and the
 * survivors are merged into one alert request.
 * Status bits are held outside; masking never touches them.
 */
`timescale 1ns/10ps
`default_nettype none
module alert_suppress_gate #(
    parameter int MASK_COUNT = 6
) (
    input wire logic [8*MASK_COUNT-1:0] status_bits,
    input wire logic [8*MASK_COUNT-1:0] mask_bits,
    output logic alert_request
);

    logic [MASK_COUNT-1:0] entry_alert;

    // A set mask bit hides its status bit from the alert only.
    for (genvar i = 0; i < MASK_COUNT; i++) begin : g_entry
        assign entry_alert[i] = |(status_bits[8*i +: 8] & ~mask_bits[8*i +: 8]);
    end

    assign alert_request = |entry_alert;

endmodule : alert_suppress_gate
`default_nettype wire

// [hdl/pmbus_write_guard_nvm_config.sv]
/*
 * Command handling for write guard, configuration save and reload, the
 * bus feature report and alert suppression masks.
 * Assumes a link layer that hands over one decoded transaction at a time
 * and stretches the bus while cmd_ready is low, an NVM port that answers
 * each request with a one-cycle ack, and an outside store that takes the
 * forwarded writes of all other commands.
 */
`timescale 1ns/10ps
`default_nettype none
module pmbus_write_guard_nvm_config #(
    parameter int MASK_COUNT = 6,
    parameter logic [8*MASK_COUNT-1:0] MASK_CODES = 48'h7F7E7D7C7B7A,
    parameter logic [8*MASK_COUNT-1:0] MASK_WRITABLE = 48'hFFFFFFFFB0FC,
    parameter logic [MASK_COUNT:0] ITEM_STORED = '1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_code,
    input wire logic [2:0] cmd_kind,
    input wire logic [15:0] cmd_data,
    input wire logic [7:0] phase_sel,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_invalid,
    output logic rsp_refused,
    output logic rsp_unclaimed,
    output logic cfg_wr_en,
    output logic [7:0] cfg_code,
    output logic [15:0] cfg_data,
    input wire logic [8*MASK_COUNT-1:0] status_bits,
    output logic alert_output,
    output logic nvm_req,
    output logic nvm_we,
    output logic [7:0] nvm_addr,
    output logic [7:0] nvm_wdata,
    input wire logic [7:0] nvm_rdata,
    input wire logic nvm_ack,
    input wire logic [MASK_COUNT:0] pin_strap_override_set,
    input wire logic [8*(MASK_COUNT+1)-1:0] pin_detect_value,
    output logic regulation_stop,
    output logic nvm_busy
);

    // Item 0 is the guard level, items 1..MASK_COUNT are the masks.
    localparam int ITEMS = MASK_COUNT + 1;
    localparam int IDX_W = $clog2(ITEMS);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(ITEMS - 1);

    // The item index must fit the byte-wide NVM address space.
    if (MASK_COUNT < 1 || MASK_COUNT > 254) begin : g_mask_count_check
        $error("MASK_COUNT must lie between 1 and 254");
    end

    logic [7:0] op_mem [ITEMS];
    pmbus_guard_pkg::nvm_state_e state;
    pmbus_guard_pkg::nvm_state_e next_state;
    logic [IDX_W-1:0] item_idx;
    logic [IDX_W-1:0] next_item_idx;
    logic take;
    logic is_write;
    logic write_allowed;
    logic proposed_valid;
    logic [MASK_COUNT-1:0] code_match;
    logic mask_hit;
    logic [IDX_W-1:0] mask_item;
    logic [7:0] mask_keep;
    logic [7:0] feature_report;
    logic [8*MASK_COUNT-1:0] mask_flat;
    logic next_store_guard;
    logic next_store_mask;
    logic next_start_save;
    logic next_start_load;
    logic next_forward;
    logic next_invalid;
    logic next_refused;
    logic next_unclaimed;
    logic [7:0] next_rsp_data;

    // Commands are only taken while the sequencer is idle; the link layer
    // stretches or drops the rest, which keeps NVM traffic uninterrupted.
    assign cmd_ready = (state == pmbus_guard_pkg::ST_IDLE);
    assign take = cmd_valid && cmd_ready;
    assign is_write = (cmd_kind != pmbus_guard_pkg::KIND_READ_BYTE) &&
                      (cmd_kind != pmbus_guard_pkg::KIND_PROCESS_CALL);

    pmbus_write_gate u_write_gate (
        .guard_level(op_mem[0]),
        .code(cmd_code),
        .proposed_level(cmd_data[7:0]),
        .write_allowed(write_allowed),
        .proposed_valid(proposed_valid)
    );

    // Compare the status code byte against every mask entry.
    for (genvar i = 0; i < MASK_COUNT; i++) begin : g_match
        assign code_match[i] = (cmd_data[7:0] == MASK_CODES[8*i +: 8]);
        assign mask_flat[8*i +: 8] = op_mem[i + 1];
    end

    // First matching entry wins; duplicate codes in MASK_CODES are pointless.
    always_comb begin
        mask_hit = 1'b0;
        mask_item = '0;
        mask_keep = 8'h00;
        for (int i = MASK_COUNT - 1; i >= 0; i--) begin
            if (code_match[i]) begin
                mask_hit = 1'b1;
                mask_item = IDX_W'(i + 1);
                mask_keep = MASK_WRITABLE[8*i +: 8];
            end
        end
    end

    // The feature report is fixed; it is built bit by bit from its layout.
    always_comb begin
        feature_report = 8'h00;
        feature_report[pmbus_guard_pkg::FEAT_PACKET_CHECK_BIT] = 1'b1;
        feature_report[pmbus_guard_pkg::FEAT_SPEED_LSB +: 2] = pmbus_guard_pkg::FEAT_SPEED_1MHZ;
        feature_report[pmbus_guard_pkg::FEAT_ALERT_BIT] = 1'b1;
        feature_report[pmbus_guard_pkg::FEAT_FORMAT_BIT] = 1'b0;
        feature_report[pmbus_guard_pkg::FEAT_ADAPTIVE_VOLTAGE_BUS_BIT] = 1'b0;
    end

    // Command decode. Reads never consult the guard level.
    always_comb begin
        next_store_guard = 1'b0;
        next_store_mask = 1'b0;
        next_start_save = 1'b0;
        next_start_load = 1'b0;
        next_forward = 1'b0;
        next_invalid = 1'b0;
        next_refused = 1'b0;
        next_unclaimed = 1'b0;
        next_rsp_data = 8'h00;
        case (cmd_code)
            pmbus_guard_pkg::CMD_WRITE_GUARD: begin
                if (!is_write) begin
                    next_rsp_data = op_mem[0];
                end else if (cmd_kind == pmbus_guard_pkg::KIND_WRITE_BYTE && proposed_valid) begin
                    next_store_guard = 1'b1;
                end else begin
                    next_invalid = 1'b1;
                end
            end
            pmbus_guard_pkg::CMD_SAVE_CONFIG: begin
                if (cmd_kind == pmbus_guard_pkg::KIND_SEND_BYTE) begin
                    next_start_save = 1'b1;
                end else begin
                    next_invalid = 1'b1;
                end
            end
            pmbus_guard_pkg::CMD_RELOAD_CONFIG: begin
                if (cmd_kind != pmbus_guard_pkg::KIND_SEND_BYTE) begin
                    next_invalid = 1'b1;
                end else if (write_allowed) begin
                    next_start_load = 1'b1;
                end else begin
                    next_refused = 1'b1;
                end
            end
            pmbus_guard_pkg::CMD_FEATURE_REPORT: begin
                if (cmd_kind == pmbus_guard_pkg::KIND_READ_BYTE) begin
                    next_rsp_data = feature_report;
                end else begin
                    next_invalid = 1'b1;
                end
            end
            pmbus_guard_pkg::CMD_ALERT_SUPPRESS: begin
                if (cmd_kind == pmbus_guard_pkg::KIND_WRITE_WORD) begin
                    if (!write_allowed) begin
                        next_refused = 1'b1;
                    end else if (phase_sel != pmbus_guard_pkg::PHASE_ALL || !mask_hit) begin
                        next_invalid = 1'b1;
                    end else begin
                        next_store_mask = 1'b1;
                    end
                end else if (cmd_kind == pmbus_guard_pkg::KIND_PROCESS_CALL) begin
                    if (phase_sel != pmbus_guard_pkg::PHASE_ALL || !mask_hit) begin
                        next_invalid = 1'b1;
                    end else begin
                        next_rsp_data = op_mem[mask_item];
                    end
                end else begin
                    next_invalid = 1'b1;
                end
            end
            default: begin
                if (!is_write) begin
                    next_unclaimed = 1'b1;
                end else if (write_allowed) begin
                    next_forward = 1'b1;
                end else begin
                    next_refused = 1'b1;
                end
            end
        endcase
    end

    // Answer and forwarded write, one cycle after the command is taken.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_invalid <= 1'b0;
            rsp_refused <= 1'b0;
            rsp_unclaimed <= 1'b0;
            cfg_wr_en <= 1'b0;
            cfg_code <= 8'h00;
            cfg_data <= 16'h0000;
        end else begin
            rsp_valid <= take;
            rsp_invalid <= take && next_invalid;
            rsp_refused <= take && next_refused;
            rsp_unclaimed <= take && next_unclaimed;
            cfg_wr_en <= take && next_forward;
            if (take) begin
                rsp_data <= next_rsp_data;
                cfg_code <= cmd_code;
                cfg_data <= cmd_data;
            end
        end
    end

    // Sequencer transitions. Items without a user-store location are
    // stepped over without an NVM request in either direction.
    always_comb begin
        next_state = state;
        next_item_idx = item_idx;
        case (state)
            pmbus_guard_pkg::ST_IDLE: begin
                next_item_idx = '0;
                if (take && next_start_save) begin
                    next_state = pmbus_guard_pkg::ST_SAVE_STEP;
                end else if (take && next_start_load) begin
                    next_state = pmbus_guard_pkg::ST_LOAD_STEP;
                end
            end
            pmbus_guard_pkg::ST_SAVE_STEP: begin
                if (ITEM_STORED[item_idx]) begin
                    next_state = pmbus_guard_pkg::ST_SAVE_WAIT;
                end else if (item_idx == LAST_IDX) begin
                    next_state = pmbus_guard_pkg::ST_IDLE;
                end else begin
                    next_item_idx = item_idx + 1'b1;
                end
            end
            pmbus_guard_pkg::ST_SAVE_WAIT: begin
                if (nvm_ack) begin
                    if (item_idx == LAST_IDX) begin
                        next_state = pmbus_guard_pkg::ST_IDLE;
                    end else begin
                        next_state = pmbus_guard_pkg::ST_SAVE_STEP;
                        next_item_idx = item_idx + 1'b1;
                    end
                end
            end
            pmbus_guard_pkg::ST_LOAD_STEP: begin
                if (ITEM_STORED[item_idx]) begin
                    next_state = pmbus_guard_pkg::ST_LOAD_WAIT;
                end else if (item_idx == LAST_IDX) begin
                    next_state = pmbus_guard_pkg::ST_OVERRIDE;
                end else begin
                    next_item_idx = item_idx + 1'b1;
                end
            end
            pmbus_guard_pkg::ST_LOAD_WAIT: begin
                if (nvm_ack) begin
                    if (item_idx == LAST_IDX) begin
                        next_state = pmbus_guard_pkg::ST_OVERRIDE;
                    end else begin
                        next_state = pmbus_guard_pkg::ST_LOAD_STEP;
                        next_item_idx = item_idx + 1'b1;
                    end
                end
            end
            pmbus_guard_pkg::ST_OVERRIDE: begin
                next_state = pmbus_guard_pkg::ST_IDLE;
            end
            default: begin
                next_state = pmbus_guard_pkg::ST_IDLE;
                next_item_idx = '0;
            end
        endcase
    end

    // Power-up starts with a reload so settings come back from NVM.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= pmbus_guard_pkg::ST_LOAD_STEP;
            item_idx <= '0;
        end else begin
            state <= next_state;
            item_idx <= next_item_idx;
        end
    end

    // Operating items. Command writes happen only in idle, NVM loads and
    // pin overrides only outside it, so the writers never collide.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            op_mem[0] <= pmbus_guard_pkg::WRITE_GUARD_RESET;
            for (int i = 1; i < ITEMS; i++) begin
                op_mem[i] <= pmbus_guard_pkg::MASK_RESET;
            end
        end else if (take && next_store_guard) begin
            op_mem[0] <= cmd_data[7:0];
        end else if (take && next_store_mask) begin
            op_mem[mask_item] <= cmd_data[15:8] & mask_keep;
        end else if (state == pmbus_guard_pkg::ST_LOAD_WAIT && nvm_ack) begin
            op_mem[item_idx] <= nvm_rdata;
        end else if (state == pmbus_guard_pkg::ST_OVERRIDE) begin
            for (int i = 0; i < ITEMS; i++) begin
                if (pin_strap_override_set[i]) begin
                    op_mem[i] <= pin_detect_value[8*i +: 8];
                end
            end
        end
    end

    // NVM port. The request holds until the ack, address and data come
    // straight from the item index and the item flops.
    assign nvm_req = (state == pmbus_guard_pkg::ST_SAVE_WAIT) || (state == pmbus_guard_pkg::ST_LOAD_WAIT);
    assign nvm_we = (state == pmbus_guard_pkg::ST_SAVE_WAIT);
    assign nvm_addr = pmbus_guard_pkg::ITEM_NVM_BASE + 8'(item_idx);
    assign nvm_wdata = op_mem[item_idx];
    assign nvm_busy = (state != pmbus_guard_pkg::ST_IDLE);

    // Regulation is held off for the whole reload including the override.
    assign regulation_stop = (state == pmbus_guard_pkg::ST_LOAD_STEP) ||
                             (state == pmbus_guard_pkg::ST_LOAD_WAIT) ||
                             (state == pmbus_guard_pkg::ST_OVERRIDE);

    alert_suppress_gate #(
        .MASK_COUNT(MASK_COUNT)
    ) u_alert_gate (
        .status_bits(status_bits),
        .mask_bits(mask_flat),
        .alert_request(alert_output)
    );

endmodule : pmbus_write_guard_nvm_config
`default_nettype wire

// [sim/nvm_store_model.sv]
/* User store model on the block's NVM port.
   Assumes the block holds its request until the ack cycle. */
`timescale 1ns/10ps
`default_nettype none
module nvm_store_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic nvm_req,
    input wire logic nvm_we,
    input wire logic [7:0] nvm_addr,
    input wire logic [7:0] nvm_wdata,
    output logic nvm_ack,
    output logic [7:0] nvm_rdata
);
    logic [7:0] mem [0:255] = '{default: 8'h00};
    logic [1:0] cnt;

    // A slow store answers only on every fourth cycle; idle read data toggles so stale values show.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 2'h0;
            nvm_ack <= 1'b0;
            nvm_rdata <= 8'h00;
        end else begin
            cnt <= cnt + 2'h1;
            nvm_ack <= nvm_req && !nvm_ack && (!slow || cnt == 2'h3);
            nvm_rdata <= (nvm_req && !nvm_ack) ? mem[nvm_addr] : ~nvm_rdata;
            if (nvm_req && nvm_we && !nvm_ack) mem[nvm_addr] <= nvm_wdata;
        end
    end
endmodule : nvm_store_model
`default_nettype wire

// [sim/pmbus_guard_properties.sv]
/* Port checker for the guard block.
   Assumes it is bound into every instance of the block. */
`timescale 1ns/10ps
`default_nettype none
module pmbus_guard_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [7:0] cmd_code,
    input wire logic [2:0] cmd_kind,
    input wire logic [15:0] cmd_data,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_invalid,
    input wire logic rsp_refused,
    input wire logic cfg_wr_en,
    input wire logic nvm_req,
    input wire logic [7:0] nvm_addr,
    input wire logic nvm_ack
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // A guard value is legal only at the four defined levels.
    wire logic ok_lv = cmd_data[7:0] inside {8'h00, 8'h20, 8'h40, 8'h80};

    sequence take_s(logic [7:0] c, logic [2:0] k);
        cmd_valid && cmd_ready && cmd_code == c && cmd_kind == k;
    endsequence

    answer_once_a: assert property (cmd_valid && cmd_ready |=> rsp_valid)
        else $error("no answer");
    answer_cause_a: assert property (rsp_valid |-> $past(cmd_valid && cmd_ready))
        else $error("stray answer");
    feature_value_a: assert property (take_s(8'h19, 3'h3) |=> rsp_data == 8'hD0 && !rsp_invalid)
        else $error("wrong feature byte");
    feature_write_a: assert property (take_s(8'h19, 3'h1) |=> rsp_invalid)
        else $error("feature write taken");
    guard_bad_a: assert property (take_s(8'h10, 3'h1) ##0 !ok_lv |=> rsp_invalid)
        else $error("bad guard taken");
    guard_open_a: assert property (take_s(8'h10, 3'h1) ##0 ok_lv |=> !rsp_invalid && !rsp_refused)
        else $error("good guard rejected");
    refuse_quiet_a: assert property (rsp_refused |-> !cfg_wr_en && !rsp_invalid)
        else $error("refused write forwarded");
    save_busy_a: assert property (take_s(8'h15, 3'h0) |=> !cmd_ready)
        else $error("save did not start");
    nvm_hold_a: assert property (nvm_req && !nvm_ack |=> nvm_req && $stable(nvm_addr))
        else $error("store request dropped");
endmodule : pmbus_guard_properties

bind pmbus_write_guard_nvm_config pmbus_guard_properties chk (.*);
`default_nettype wire

// [sim/tb_top.sv]
/* Self-checking bench: host tasks, reference model and checks.
   Assumes the store model answers every request. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk, rstn, cmd_valid, cmd_ready, rsp_valid, rsp_invalid, rsp_refused, rsp_unclaimed, cfg_wr_en;
    logic alert_output, nvm_req, nvm_we, nvm_ack, regulation_stop, nvm_busy, slow, saw, r_inv, r_ref, r_cfg, r_unc;
    logic [7:0] cmd_code, phase_sel, rsp_data, cfg_code, nvm_addr, nvm_wdata, nvm_rdata, r_data, v;
    logic [2:0] cmd_kind;
    logic [15:0] cmd_data, cfg_data;
    logic [47:0] status_bits;
    logic [6:0] pin_strap_override_set;
    logic [55:0] pin_detect_value;
    int bad_count = 0, compares = 0, lv, m;
    int levels[4] = '{0, 'h20, 'h40, 'h80};
    int codes[4] = '{1, 2, 'h21, 'h1B};

    pmbus_write_guard_nvm_config dut (.*);
    nvm_store_model nvm (.*);

    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Which writes each guard level lets through.
    function automatic bit allowed(int l, int c);
        if (c == 'h10 || c == 'h15 || l == 0) return 1;
        if (l == 'h80) return 0;
        if (c == 1) return 1;
        return l == 'h20 && (c == 2 || c == 'h21);
    endfunction : allowed

    task automatic finish_test();
        if (bad_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: flag %b not %b", $time, got, exp);
        end
    endtask : chk1

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: byte %h not %h", $time, got, exp);
        end
    endtask : chk8

    // Lets an edge pass so valid never drops and rises in one step, waits for idle, offers one command.
    task automatic cmd(input logic [7:0] c, input logic [2:0] k, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 500) begin
            saw |= regulation_stop;
            @(negedge clk);
            n++;
        end
        chk1(cmd_ready, 1'b1);
        cmd_code = c;
        cmd_kind = k;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        chk1(rsp_valid, 1'b1);
        {r_data, r_inv, r_ref, r_cfg, r_unc} = {rsp_data, rsp_invalid, rsp_refused, cfg_wr_en, rsp_unclaimed};
    endtask : cmd

    // Hang guard, far beyond the expected run length.
    initial begin
        #2000000;
        bad_count++;
        finish_test();
    end

    // Main sequence; inputs change on the falling edge.
    initial begin
        void'($urandom(30));
        {rstn, cmd_valid, slow, saw, m} = '0;
        {cmd_code, cmd_kind, cmd_data, status_bits} = '0;
        phase_sel = 8'hFF;
        pin_strap_override_set = 7'h00;
        pin_detect_value = 56'({$urandom, $urandom});
        repeat (3) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        cmd(8'h19, 3'h3, 16'h0000);
        chk8(r_data, 8'hD0);
        cmd(8'h19, 3'h1, 16'h00D0);
        chk1(r_inv, 1'b1);
        foreach (levels[i]) begin
            lv = levels[i];
            cmd(8'h10, 3'h1, 16'(lv));
            chk1(r_inv, 1'b0);
            foreach (codes[j]) begin
                v = 8'($urandom);
                cmd(8'(codes[j]), codes[j] == 'h1B ? 3'h2 : 3'h1, {v, codes[j] == 'h1B ? 8'h7A : v});
                chk8(cfg_code, 8'(codes[j]));
                chk1(r_ref, !allowed(lv, codes[j]));
                if (codes[j] != 'h1B) chk1(r_cfg, allowed(lv, codes[j]));
                else if (allowed(lv, 'h1B)) m = v & 8'hFC;
            end
            cmd(8'h1B, 3'h4, 16'h007A);
            chk8(r_data, 8'(m));
            do v = 8'($urandom); while (v inside {8'h00, 8'h20, 8'h40, 8'h80});
            cmd(8'h10, 3'h1, {8'h00, v});
            chk1(r_inv, 1'b1);
            cmd(8'h10, 3'h3, 16'h0000);
            chk8(r_data, 8'(lv));
        end
        cmd(8'h01, 3'h3, 16'h0000);
        chk1(r_unc, 1'b1);
        cmd(8'h10, 3'h1, 16'h0000);
        phase_sel = 8'h00;
        cmd(8'h1B, 3'h4, 16'h007A);
        chk1(r_inv, 1'b1);
        phase_sel = 8'hFF;
        cmd(8'h1B, 3'h2, 16'h807A);
        status_bits[7:0] = 8'h80;
        #1 chk1(alert_output, 1'b0);
        cmd(8'h1B, 3'h2, 16'h007A);
        chk1(alert_output, 1'b1);
        status_bits[7:0] = 8'h00;
        m = 8'($urandom) & 8'hFC;
        cmd(8'h1B, 3'h2, {8'(m), 8'h7A});
        slow = 1'b1;
        cmd(8'h15, 3'h0, 16'h0000);
        cmd(8'h10, 3'h3, 16'h0000);
        chk8(nvm.mem[0], 8'h00);
        chk8(nvm.mem[1], 8'(m));
        cmd(8'h1B, 3'h2, {8'(~m), 8'h7A});
        v = 8'($urandom) & 8'hB0;
        pin_detect_value[23:16] = v;
        pin_strap_override_set = 7'h04;
        saw = 1'b0;
        cmd(8'h16, 3'h0, 16'h0000);
        cmd(8'h1B, 3'h4, 16'h007A);
        chk8(r_data, 8'(m));
        chk1(saw, 1'b1);
        cmd(8'h1B, 3'h4, 16'h007B);
        chk8(r_data, v);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
